/* design/lbic_ctrl.sv */
// Serial slave, register file and LED drive logic of the LED brightness controller
`timescale 1ns/1ps
`default_nettype none
module lbic_ctrl
#(
  parameter int NUM_MAIN = 5
)
(
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe,
  input  wire logic [NUM_MAIN-1:0] main_low_headroom,
  output logic [NUM_MAIN-1:0]      main_sinks_on,
  output logic [1:0]               main_level,
  output logic                     aux_sink_on,
  output logic [1:0]               aux_level,
  output logic                     pump_gain_boost,
  output logic                     bus_busy
);
  import lbic_pkg::*;

  typedef enum logic [4:0]
  {
    LBIC_IDLE = 5'b00001,
    LBIC_RECV = 5'b00010,
    LBIC_ACK  = 5'b00100,
    LBIC_WAIT = 5'b01000,
    LBIC_SKIP = 5'b10000
  } lbic_state_t;

  logic              scl_s;
  logic              sda_s;
  logic              scl_prev_q;
  logic              sda_prev_q;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_det;
  logic              stop_det;
  lbic_state_t       state_q;
  logic [3:0]        bit_cnt_q;
  logic [7:0]        shift_q;
  logic [1:0]        byte_idx_q;
  logic [7:0]        reg_ptr_q;
  logic [7:0]        gen_ctrl_q;
  logic [7:0]        main_bright_q;
  logic [7:0]        aux_bright_q;
  logic              wr_strobe;
  logic [7:0]        rx_byte;
  logic [8:0]        pwm_cnt_q;
  logic [13:0]       pwm_pos;
  logic [13:0]       pwm_lim;
  logic [1:0]        lvl_d;
  logic [4:0]        duty_num;
  logic              pwm_on;
  logic [4:0]        code;
  logic [NUM_MAIN-1:0] sense_mask;
  logic [NUM_MAIN-1:0] low_s;
  logic [NUM_MAIN-1:0] low_meta_q;

  // Bus pins pass two flops before any decode
  lbic_sync u_sync_scl
  (
    .clk    (clk),
    .resetn (resetn),
    .din    (scl_in),
    .dout   (scl_s)
  );

  lbic_sync u_sync_sda
  (
    .clk    (clk),
    .resetn (resetn),
    .din    (sda_in),
    .dout   (sda_s)
  );

  // Previous samples for edge detection
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  // Edge and condition decode; host keeps data still while clock high
  assign scl_rise  = scl_s & ~scl_prev_q;
  assign scl_fall  = ~scl_s & scl_prev_q;
  assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  assign rx_byte   = shift_q;

  // Busy flag follows start and stop
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      bus_busy <= 1'b0;
    else if (start_det)
      bus_busy <= 1'b1;
    else if (stop_det)
      bus_busy <= 1'b0;
  end

  // Byte receiver and acknowledge sequencer
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q    <= LBIC_IDLE;
      bit_cnt_q  <= 4'h0;
      shift_q    <= 8'h00;
      byte_idx_q <= 2'h0;
    end
    else if (start_det)
    begin
      // Repeated start behaves exactly like a first one
      state_q    <= LBIC_RECV;
      bit_cnt_q  <= 4'h0;
      byte_idx_q <= 2'h0;
    end
    else if (stop_det)
      state_q <= LBIC_IDLE;
    else
    begin
      case (state_q)
        LBIC_IDLE:
          state_q <= LBIC_IDLE;
        LBIC_RECV:
        begin
          // Sample on rising clock, MSB first
          if (scl_rise)
          begin
            shift_q   <= {shift_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          else if (scl_fall && bit_cnt_q == 4'(LBIC_BIT_COUNT))
          begin
            bit_cnt_q <= 4'h0;
            // Address mismatch or read: stay silent until next start
            if (byte_idx_q == 2'h0 && rx_byte != {LBIC_SLAVE_ADDR, 1'b0})
              state_q <= LBIC_SKIP;
            else
              state_q <= LBIC_ACK;
          end
        end
        LBIC_ACK:
        begin
          // Hold low through the ninth pulse, release on its falling edge
          if (scl_fall)
          begin
            state_q    <= (byte_idx_q == 2'h2) ? LBIC_WAIT : LBIC_RECV;
            byte_idx_q <= (byte_idx_q == 2'h2) ? byte_idx_q : byte_idx_q + 2'h1;
          end
        end
        LBIC_WAIT:
          state_q <= LBIC_WAIT; // Extra bytes are not acknowledged
        LBIC_SKIP:
          state_q <= LBIC_SKIP;
        default:
          state_q <= LBIC_IDLE;
      endcase
    end
  end

  // Acknowledge drive: open-drain, only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe  = (state_q == LBIC_ACK);

  // Register pointer is the second byte
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      reg_ptr_q <= 8'h00;
    else if (state_q == LBIC_RECV && scl_fall && bit_cnt_q == 4'(LBIC_BIT_COUNT)
             && byte_idx_q == 2'h1)
      reg_ptr_q <= rx_byte;
  end

  // Third byte commits a write
  assign wr_strobe = (state_q == LBIC_RECV) && scl_fall
                     && (bit_cnt_q == 4'(LBIC_BIT_COUNT)) && (byte_idx_q == 2'h2);

  // Register file; reset pin restores defaults
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gen_ctrl_q    <= LBIC_RST_GEN_CTRL;
      main_bright_q <= LBIC_RST_MAIN_BRIGHT;
      aux_bright_q  <= LBIC_RST_AUX_BRIGHT;
    end
    else if (wr_strobe)
    begin
      case (reg_ptr_q)
        // Bits 7..5 are fixed; test bits stored as written
        LBIC_OFS_GEN_CTRL:
          gen_ctrl_q <= LBIC_RST_GEN_CTRL | (rx_byte & ~LBIC_GEN_FIXED_MASK);
        // Unused bits keep their fixed ones
        LBIC_OFS_MAIN_BRIGHT:
          main_bright_q <= {3'h7, rx_byte[4:0]};
        LBIC_OFS_AUX_BRIGHT:
          aux_bright_q <= {6'h3f, rx_byte[1:0]};
        default:
          gen_ctrl_q <= gen_ctrl_q;
      endcase
    end
  end

  // Frame counter fixes the 20 kHz period; the code only moves the on-time
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pwm_cnt_q <= 9'h000;
    else if (pwm_cnt_q == 9'(LBIC_PWM_PERIOD - 1))
      pwm_cnt_q <= 9'h000;
    else
      pwm_cnt_q <= pwm_cnt_q + 9'h001;
  end

  // Main code to analog level and duty numerator
  assign code = main_bright_q[4:0];
  always_comb
  begin
    lvl_d    = LBIC_LVL_20;
    duty_num = 5'h00;
    if (code <= 5'h0f)
    begin
      lvl_d    = LBIC_LVL_20;
      duty_num = code + 5'h01;
    end
    else if (code <= 5'h16)
    begin
      lvl_d    = LBIC_LVL_40;
      duty_num = code - 5'h06;
    end
    else if (code <= 5'h1c)
    begin
      lvl_d    = LBIC_LVL_70;
      duty_num = code - 5'h0c;
    end
    else
    begin
      lvl_d = LBIC_LVL_100;
      case (code)
        5'h1d:   duty_num = 5'h0d;
        5'h1e:   duty_num = 5'h0f;
        default: duty_num = 5'h10;
      endcase
    end
  end

  // Duty in sixteenths of the frame; the frame does not split evenly into sixteen
  // slots, so the position times sixteen is compared with duty times frame length
  assign pwm_pos = {1'b0, pwm_cnt_q, 4'h0};
  assign pwm_lim = 14'(duty_num) * 14'(LBIC_PWM_PERIOD);
  assign pwm_on  = (pwm_pos < pwm_lim);

  // Level and bank gate come from flops so the sinks never see decode glitches
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      main_level    <= LBIC_LVL_20;
      main_sinks_on <= '0;
    end
    else
    begin
      main_level    <= lvl_d;
      // Stored codes stay dark until the bank is enabled
      main_sinks_on <= (gen_ctrl_q[LBIC_BIT_MAIN_EN] && pwm_on)
                       ? {NUM_MAIN{1'b1}} : {NUM_MAIN{1'b0}};
    end
  end
  assign aux_sink_on   = gen_ctrl_q[LBIC_BIT_AUX_EN];
  assign aux_level     = aux_bright_q[1:0];

  // Headroom comparators are asynchronous to this clock
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      low_meta_q <= '0;
      low_s      <= '0;
    end
    else
    begin
      low_meta_q <= main_low_headroom;
      low_s      <= low_meta_q;
    end
  end

  // Fifth sink monitored only when its sense bit is set
  always_comb
  begin
    sense_mask = {NUM_MAIN{1'b1}};
    sense_mask[NUM_MAIN-1] = gen_ctrl_q[LBIC_BIT_SENSE5_EN];
  end

  // Boost once any active monitored main sink is short of headroom; aux never counted
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pump_gain_boost <= 1'b0;
    else if (!gen_ctrl_q[LBIC_BIT_MAIN_EN])
      pump_gain_boost <= 1'b0;
    else if (|(low_s & sense_mask))
      pump_gain_boost <= 1'b1;
  end
endmodule : lbic_ctrl
`default_nettype wire

/* design/lbic_pkg.sv */
// Package: constants for the LED brightness serial control block
package lbic_pkg;
  localparam logic [6:0] LBIC_SLAVE_ADDR      = 7'h36;
  localparam logic [7:0] LBIC_OFS_GEN_CTRL    = 8'h10;
  localparam logic [7:0] LBIC_OFS_MAIN_BRIGHT = 8'ha0;
  localparam logic [7:0] LBIC_OFS_AUX_BRIGHT  = 8'hc0;
  localparam logic [7:0] LBIC_RST_GEN_CTRL    = 8'h20;
  localparam logic [7:0] LBIC_RST_MAIN_BRIGHT = 8'he0;
  localparam logic [7:0] LBIC_RST_AUX_BRIGHT  = 8'hfc;
  // General control field positions
  localparam int LBIC_BIT_MAIN_EN   = 0;
  localparam int LBIC_BIT_TEST_LOW  = 1;
  localparam int LBIC_BIT_AUX_EN    = 2;
  localparam int LBIC_BIT_SENSE5_EN = 3;
  localparam int LBIC_BIT_TEST_HIGH = 4;
  // Fixed bits of the general control register
  localparam logic [7:0] LBIC_GEN_FIXED_MASK = 8'he0;
  // Analog level selections
  localparam logic [1:0] LBIC_LVL_20  = 2'h0;
  localparam logic [1:0] LBIC_LVL_40  = 2'h1;
  localparam logic [1:0] LBIC_LVL_70  = 2'h2;
  localparam logic [1:0] LBIC_LVL_100 = 2'h3;
  // PWM timing and serial byte length
  localparam int LBIC_CLK_HZ      = 10_000_000;
  localparam int LBIC_PWM_HZ      = 20_000;
  localparam int LBIC_PWM_PERIOD  = LBIC_CLK_HZ / LBIC_PWM_HZ;
  localparam int LBIC_PWM_STEPS   = 16;
  localparam int LBIC_PWM_SLOT    = LBIC_PWM_PERIOD / LBIC_PWM_STEPS;
  localparam int LBIC_BIT_COUNT   = 8;
endpackage : lbic_pkg

/* design/lbic_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module lbic_sync
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic din,
  output logic      dout
);
  logic meta_q;

  // Resets high to match an idle pulled-up bus line
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_q <= 1'b1;
      dout   <= 1'b1;
    end
    else
    begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : lbic_sync
`default_nettype wire

/* testbench/lbic_ctrl_properties.sv */
// Port-level checker for the LED brightness controller
`timescale 1ns/1ps
`default_nettype none
module lbic_ctrl_properties
#(
  parameter int NUM_MAIN = 5
)
(
  input wire logic                clk,
  input wire logic                resetn,
  input wire logic                scl_in,
  input wire logic                sda_in,
  input wire logic                sda_out,
  input wire logic                sda_oe,
  input wire logic [NUM_MAIN-1:0] main_low_headroom,
  input wire logic [NUM_MAIN-1:0] main_sinks_on,
  input wire logic [1:0]          main_level,
  input wire logic                aux_sink_on,
  input wire logic [1:0]          aux_level,
  input wire logic                pump_gain_boost,
  input wire logic                bus_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [3:0] hr_age_q;
  // Age of the last headroom flag; boost may only follow a recent one
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      hr_age_q <= 4'hf;
    else if (|main_low_headroom)
      hr_age_q <= 4'h0;
    else if (hr_age_q != 4'hf)
      hr_age_q <= hr_age_q + 4'h1;
  property p_rst;
    $rose(resetn) |-> !bus_busy && !sda_oe && !aux_sink_on && !pump_gain_boost
      && main_sinks_on == '0 && main_level == 2'h0 && aux_level == 2'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not at defaults");
  property p_start;
    scl_in && $past(scl_in) && $fell(sda_in) |-> ##[2:6] bus_busy;
  endproperty
  a_start: assert property (p_start) else $error("start not seen");
  property p_stop;
    scl_in && $past(scl_in) && $rose(sda_in) |-> ##[2:6] !bus_busy;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not seen");
  property p_oe_busy;
    sda_oe |-> bus_busy;
  endproperty
  a_oe_busy: assert property (p_oe_busy) else $error("ack outside transfer");
  property p_oe_edge;
    $changed(sda_oe) |-> !scl_in && !$past(scl_in, 2);
  endproperty
  a_oe_edge: assert property (p_oe_edge) else $error("ack moved with clock high");
  property p_oe_hold;
    $rose(scl_in) && sda_oe |-> sda_oe [*4];
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("ack dropped in pulse");
  property p_bank;
    main_sinks_on == '0 || main_sinks_on == '1;
  endproperty
  a_bank: assert property (p_bank) else $error("main bank split");
  property p_boost_cause;
    $rose(pump_gain_boost) |-> hr_age_q < 4'h8;
  endproperty
  a_boost_cause: assert property (p_boost_cause) else $error("boost without cause");
  property p_boost_clr;
    $fell(pump_gain_boost) |-> main_sinks_on == '0;
  endproperty
  a_boost_clr: assert property (p_boost_clr) else $error("boost dropped early");
  property p_lvl;
    !bus_busy |-> $stable(main_level) && $stable(aux_level);
  endproperty
  a_lvl: assert property (p_lvl) else $error("level moved while idle");
endmodule : lbic_ctrl_properties
bind lbic_ctrl lbic_ctrl_properties #(.NUM_MAIN(NUM_MAIN)) i_lbic_ctrl_properties (
  .clk(clk), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .main_low_headroom(main_low_headroom), .main_sinks_on(main_sinks_on),
  .main_level(main_level), .aux_sink_on(aux_sink_on), .aux_level(aux_level),
  .pump_gain_boost(pump_gain_boost), .bus_busy(bus_busy));
`default_nettype wire

/* testbench/lbic_host_model.sv */
// Host serial bus master model: clock and open-drain data pull
`timescale 1ns/1ps
`default_nettype none
module lbic_host_model
(
  input  wire logic clk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_low
);
  // Quarter of a bit: two 100 ns clocks give an 800 ns serial clock
  localparam int QTR = 2;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic q(input int n);
    repeat (n) @(negedge clk);
  endtask : q
  // Start or repeated start; data released while the clock is low, then pulled low while the clock is high
  task automatic start();
    sda_low = 1'b0;
    q(QTR);
    scl = 1'b1;
    q(QTR);
    sda_low = 1'b1;
    q(QTR);
    scl = 1'b0;
    q(QTR);
  endtask : start
  // Stop ends the transfer and frees the bus
  task automatic stop();
    sda_low = 1'b1;
    q(QTR);
    scl = 1'b1;
    q(QTR);
    sda_low = 1'b0;
    // Give the stop time to pass the device's synchronisers
    q(2 * QTR);
  endtask : stop
  // Eight bits MSB first, then data released for the ack pulse
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 8; i >= 0; i--)
    begin
      sda_low = (i > 0) ? !d[i-1] : 1'b0;
      q(QTR);
      scl = 1'b1;
      q(QTR);
      r = sda;
      q(QTR);
      scl = 1'b0;
      q(QTR);
    end
    ack = !r;
  endtask : put
endmodule : lbic_host_model
`default_nettype wire

/* testbench/tb_top.sv */
// Testbench top: host model writes registers, a reference model checks the LED outputs
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lbic_pkg::*;
  logic       clk;
  logic       resetn = 1'b0;
  logic [4:0] hr = 5'h00;
  logic       scl;
  logic       sda;
  logic       h_low;
  logic       d_out;
  logic       d_oe;
  logic [4:0] m_on;
  logic [1:0] m_lvl;
  logic       a_on;
  logic [1:0] a_lvl;
  logic       boost;
  logic       busy;
  logic       ak;
  int         error_cnt = 0;
  int         n_checks = 0;
  int         gen_m = 32'h20;
  int         main_m = 32'he0;
  int         aux_m = 32'hfc;
  // Pull-up wins unless a party pulls low
  assign sda = !((d_oe && !d_out) || h_low);
  lbic_ctrl i_lbic_ctrl (.clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda),
    .sda_out(d_out), .sda_oe(d_oe), .main_low_headroom(hr), .main_sinks_on(m_on),
    .main_level(m_lvl), .aux_sink_on(a_on), .aux_level(a_lvl), .pump_gain_boost(boost),
    .bus_busy(busy));
  lbic_host_model i_lbic_host_model (.clk(clk), .sda(sda), .scl(scl), .sda_low(h_low));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("mismatches %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // Whole write frame; the model stores only what a matching address carries
  task automatic wr(input logic [7:0] a, input logic [7:0] r, input logic [7:0] d);
    logic k0, k1, k2;
    i_lbic_host_model.start();
    i_lbic_host_model.put(a, k0);
    i_lbic_host_model.put(r, k1);
    i_lbic_host_model.put(d, k2);
    chk(busy, 1'b1);
    i_lbic_host_model.stop();
    chk(busy, 1'b0);
    chk({k0, k1, k2}, (a == {LBIC_SLAVE_ADDR, 1'b0}) ? 3'h7 : 3'h0);
    if (a == {LBIC_SLAVE_ADDR, 1'b0})
      case (r)
        8'h10: gen_m = (d & 8'h1f) | 8'h20;
        8'ha0: main_m = d | 8'he0;
        8'hc0: aux_m = d | 8'hfc;
        default: ;
      endcase
  endtask : wr
  // One full PWM period: on-time, levels and aux outputs against the model
  task automatic frame();
    int hi, c, duty, lvl;
    hi = 0;
    c = main_m & 31;
    repeat (LBIC_PWM_PERIOD)
    begin
      @(negedge clk);
      hi += m_on[0];
    end
    lvl = (c < 16) ? 0 : (c < 23) ? 1 : (c < 29) ? 2 : 3;
    duty = (c < 16) ? c + 1 : (c < 23) ? c - 6 : (c < 29) ? c - 12 : (c == 29) ? 13 : c - 15;
    if (gen_m[0] == 0)
      duty = 0;
    chk(m_lvl, lvl[1:0]);
    chk(hi[15:0], 16'((duty * LBIC_PWM_PERIOD + LBIC_PWM_STEPS - 1) / LBIC_PWM_STEPS));
    chk(a_on, gen_m[2]);
    chk(a_lvl, aux_m[1:0]);
  endtask : frame
  // Test bits are always written as zero reset held high in use
  initial
  begin
    void'($urandom(32'h8143b714));
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    frame();
    wr(8'h6e, 8'h10, 8'h05);
    wr(8'h6d, 8'h10, 8'h05);
    wr(8'h6c, 8'ha0, 8'h1f);
    wr(8'h6c, 8'hb0, 8'h03);
    frame();
    wr(8'h6c, 8'h10, 8'h05);
    for (int i = 0; i < 32; i++)
    begin
      wr(8'h6c, 8'ha0, {3'($urandom), i[4:0]});
      frame();
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h6c, 8'hc0, {6'($urandom), i[1:0]});
      frame();
    end
    // Aborted frame then repeated start must not leak into the brightness
    i_lbic_host_model.start();
    i_lbic_host_model.put(8'h6c, ak);
    i_lbic_host_model.put(8'ha0, ak);
    wr(8'h6c, 8'hc0, 8'h02);
    frame();
    // Fifth sink unmonitored with sense off; monitored flags raise boost
    hr = 5'h10;
    wr(8'h6c, 8'h10, 8'h05);
    chk(boost, 1'b0);
    wr(8'h6c, 8'h10, 8'h0d);
    chk(boost, 1'b1);
    hr = 5'h00;
    wr(8'h6c, 8'h10, 8'h04);
    chk(boost, 1'b0);
    hr = 5'h01;
    wr(8'h6c, 8'h10, 8'h01);
    chk(boost, 1'b1);
    // Reset in mid-run restores every default
    hr = 5'h00;
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    gen_m = 32'h20;
    main_m = 32'he0;
    aux_m = 32'hfc;
    repeat (4) @(negedge clk);
    chk(boost, 1'b0);
    frame();
    summarize();
  end
  // Watchdog sized well past the expected run length
  initial
  begin
    #10_000_000;
    error_cnt++;
    summarize();
  end
endmodule : tb_top
`default_nettype wire
